// File: hdl/barrier_consts.svh
`ifndef BARRIER_CONSTS_SVH
`define BARRIER_CONSTS_SVH

// =============================================
// Timing
`define CLK_PERIOD_NS 4
`define TICK_MS 100
`define TICK_CYCLES ((`TICK_MS * 1000000) / `CLK_PERIOD_NS)
`define CLOSE_DELAY_MS 4000
`define EMG_YELLOW_MS 3000
`define MODE_YELLOW_MS 2000
`define FLASH_MS 1000
`define HORN_S 10

// =============================================
// Register map (byte offsets)
`define REG_CFG 4'h0
`define REG_HORN 4'h4
`define REG_STATUS 4'h8

// =============================================
// Configuration fields and reset values
`define CFG_RST_BEACON 0
`define CFG_TL_BEACON 1
`define CFG_MULTI 2
`define CFG_SPAN 3
`define CFG_W 4
`define CFG_RESET 4'h0
`define HORN_RESET 8'h0a
`define STAT_W 9

// =============================================
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hdl/barrier_mode_ctrl.sv
`timescale 1ns/1ps
`include "barrier_consts.svh"

// Notes on behaviour
// RULE_01: Emergency mode arms closure and ignores master and local open/close switches.
// RULE_02: Emergency mode with barrier open keeps the signal head dark.
// RULE_03: Emergency closure starts four seconds after the trigger.
// RULE_04: Warning beacons come on at once when a trigger is seen.
// RULE_05: During the delay the head shows yellow three seconds, then alternating red.
// RULE_06: In-pavement lights are on exactly while the head shows red.
// RULE_07: After the delay, energize emergency close only while both detectors are clear.
// RULE_08: Occupied detector latches the close request; deploy when clear unless cleared.
// RULE_09: Horn sounds for a programmable time, ten seconds by default.
// RULE_10: After activation all station lamps steady red, pressed station flashes.
// RULE_11: After activation all operating commands are refused until the latch clear.
// RULE_12: Latch clear drops the close request and optionally the beacons.
// RULE_13: Head goes dark only with barrier open and selector back in emergency mode.
// RULE_14: Test mode takes master switches, ignores local switches and all triggers.
// RULE_15: Barrier spanning both directions loses emergency capability in test mode.
// RULE_16: Entering test mode runs two seconds yellow, then alternating red.
// RULE_17: Test moves are allowed once red flashes; red holds until dark conditions.
// RULE_18: Beacons stay off in test and local modes unless configured on.
// RULE_19: Local mode ignores master switches and triggers; spanning barrier loses emergency.
// RULE_20: Local panel switches act only with the local key switch at local.
// RULE_21: Single-barrier local entry runs yellow then red; moves only once red flashes.
// RULE_22: Multi-barrier local entry leaves head unchanged, pavement lights and beacons off.
// RULE_23: Red lamps and indicators alternate from a parameterised one-second phase.
module barrier_mode_ctrl #(
    parameter int N = 4,
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] selMode,
    input wire logic farDirNotEmg,
    input wire logic masterOpen,
    input wire logic masterClose,
    input wire logic localKey,
    input wire logic localOpen,
    input wire logic localClose,
    input wire logic [N-1:0] trigBtn,
    input wire logic latchClear,
    input wire logic presenceFront,
    input wire logic presenceBack,
    input wire logic barrierOpen,
    output logic openCmd,
    output logic closeCmd,
    output logic emergencyClose,
    output logic headYellow,
    output logic headRedA,
    output logic headRedB,
    output logic pavementLights,
    output logic beacons,
    output logic horn,
    output logic [N-1:0] stationLamp,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int TW = $clog2(TICK_CYCLES);
    localparam int DLY = `CLOSE_DELAY_MS / `TICK_MS;
    localparam int EYEL = `EMG_YELLOW_MS / `TICK_MS;
    localparam int MYEL = `MODE_YELLOW_MS / `TICK_MS;
    localparam int FLSH = `FLASH_MS / `TICK_MS;

    generate
        if (N < 1 || N > 16 || TICK_CYCLES < 2) begin : g_bad
            $error("barrier_mode_ctrl: unsupported parameters");
        end
    endgenerate

    typedef struct packed {
        logic [TW-1:0] tickCnt;
        logic [3:0] flashCnt;
        logic phase;
        barrier_pkg::head_t head;
        logic [7:0] headTmr;
        barrier_pkg::seq_t seq;
        logic [7:0] seqTmr;
        logic [11:0] hornTmr;
        logic beaconLatch;
        logic [N-1:0] trigPrev;
        logic [N-1:0] pressed;
        logic [`CFG_W-1:0] cfg;
        logic [7:0] hornSec;
        logic awHave;
        logic [3:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awRdy;
        logic wRdy;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic openCmd;
        logic closeCmd;
        logic emClose;
        logic yel;
        logic redA;
        logic redB;
        logic pave;
        logic beacon;
        logic horn;
        logic [N-1:0] lamp;
    } st_t;

    st_t st_r;
    st_t st_nxt;
    logic tick;
    logic start;
    logic armed;
    logic multi;
    logic clear;

    // =============================================
    // Mode decode and trigger detection
    assign tick = (st_r.tickCnt == TW'(TICK_CYCLES - 1));
    assign multi = st_r.cfg[`CFG_MULTI];
    assign clear = !presenceFront && !presenceBack;
    // Span disarms when the other direction leaves emergency
    assign armed = (selMode == barrier_pkg::MODE_EMG)
        && !(st_r.cfg[`CFG_SPAN] && farDirNotEmg); // [RULE_01] [RULE_15] [RULE_19]
    assign start = armed && (st_r.seq == barrier_pkg::SEQ_IDLE)
        && |(trigBtn & ~st_r.trigPrev); // [RULE_14]

    // =============================================
    // Next state
    always_comb begin
        logic movOk;
        logic red;
        logic wrOk;
        movOk = 1'b0;
        red = 1'b0;
        wrOk = 1'b0;
        st_nxt = st_r;
        st_nxt.trigPrev = trigBtn;

        // One tick per 100 ms; flash phase toggles every FLSH ticks
        st_nxt.tickCnt = tick ? '0 : st_r.tickCnt + 1'b1;
        if (tick) begin
            if (st_r.flashCnt == 4'(FLSH - 1)) begin
                st_nxt.flashCnt = '0;
                st_nxt.phase = !st_r.phase; // [RULE_23]
            end else begin
                st_nxt.flashCnt = st_r.flashCnt + 1'b1;
            end
        end

        // Emergency sequence
        case (st_r.seq)
            barrier_pkg::SEQ_IDLE: begin
                if (start) begin
                    st_nxt.seq = barrier_pkg::SEQ_DELAY;
                    st_nxt.seqTmr = '0;
                    st_nxt.pressed = trigBtn & ~st_r.trigPrev;
                    st_nxt.beaconLatch = 1'b1; // [RULE_04]
                    st_nxt.hornTmr = 12'(st_r.hornSec * 4'd10); // [RULE_09]
                end
            end
            barrier_pkg::SEQ_DELAY: begin
                if (tick) begin
                    st_nxt.seqTmr = st_r.seqTmr + 1'b1;
                end
                if (tick && st_r.seqTmr == 8'(DLY - 1)) begin // [RULE_03]
                    if (clear) begin
                        st_nxt.seq = barrier_pkg::SEQ_CLOSED;
                        st_nxt.emClose = 1'b1; // [RULE_07]
                    end else begin
                        st_nxt.seq = barrier_pkg::SEQ_HOLD; // [RULE_08]
                    end
                end
            end
            barrier_pkg::SEQ_HOLD: begin
                if (clear) begin
                    st_nxt.seq = barrier_pkg::SEQ_CLOSED;
                    st_nxt.emClose = 1'b1; // [RULE_08]
                end
            end
            barrier_pkg::SEQ_CLOSED: begin
            end
            default: st_nxt.seq = barrier_pkg::SEQ_IDLE;
        endcase
        // Clear comes last so it beats a same-cycle deploy
        if (latchClear && st_r.seq != barrier_pkg::SEQ_IDLE) begin
            st_nxt.seq = barrier_pkg::SEQ_IDLE;
            st_nxt.emClose = 1'b0; // [RULE_12]
            st_nxt.pressed = '0;
            if (st_r.cfg[`CFG_RST_BEACON]) begin
                st_nxt.beaconLatch = 1'b0; // [RULE_12]
            end
        end
        if (tick && st_r.hornTmr != '0 && !start) begin
            st_nxt.hornTmr = st_r.hornTmr - 1'b1;
        end

        // Signal head
        case (st_r.head)
            barrier_pkg::HEAD_DARK: begin
                if (start || selMode == barrier_pkg::MODE_TEST
                    || (selMode == barrier_pkg::MODE_LOCAL && !multi)) begin // [RULE_16] [RULE_21] [RULE_22]
                    st_nxt.head = barrier_pkg::HEAD_YELLOW;
                    st_nxt.headTmr = '0;
                end
            end
            barrier_pkg::HEAD_YELLOW: begin
                if (tick) begin
                    st_nxt.headTmr = st_r.headTmr + 1'b1;
                    // Emergency runs use the longer yellow
                    if (st_r.headTmr == ((st_r.seq != barrier_pkg::SEQ_IDLE) ? 8'(EYEL - 1) : 8'(MYEL - 1))) begin
                        st_nxt.head = barrier_pkg::HEAD_RED; // [RULE_05] [RULE_16]
                    end
                end
            end
            barrier_pkg::HEAD_RED: begin
                if (selMode == barrier_pkg::MODE_EMG && barrierOpen
                    && st_r.seq == barrier_pkg::SEQ_IDLE) begin
                    st_nxt.head = barrier_pkg::HEAD_DARK; // [RULE_13] [RULE_17]
                end
            end
            default: st_nxt.head = barrier_pkg::HEAD_DARK;
        endcase
        if (st_nxt.head == barrier_pkg::HEAD_DARK) begin
            st_nxt.beaconLatch = 1'b0;
        end
        if (start) begin
            st_nxt.beaconLatch = 1'b1; // [RULE_04]
        end

        // Operating commands
        st_nxt.openCmd = 1'b0;
        st_nxt.closeCmd = 1'b0;
        if (st_r.seq == barrier_pkg::SEQ_IDLE) begin // [RULE_11]
            if (selMode == barrier_pkg::MODE_TEST) begin
                movOk = (st_r.head == barrier_pkg::HEAD_RED); // [RULE_17]
                st_nxt.openCmd = movOk && masterOpen; // [RULE_14]
                st_nxt.closeCmd = movOk && masterClose && !masterOpen;
            end else if (selMode == barrier_pkg::MODE_LOCAL) begin
                movOk = localKey && (multi || st_r.head == barrier_pkg::HEAD_RED); // [RULE_20] [RULE_21]
                st_nxt.openCmd = movOk && localOpen; // [RULE_19]
                st_nxt.closeCmd = movOk && localClose && !localOpen;
            end
        end

        // Lamp outputs follow the next state so each sits in a flop
        red = (st_nxt.head == barrier_pkg::HEAD_RED);
        st_nxt.yel = (st_nxt.head == barrier_pkg::HEAD_YELLOW); // [RULE_02]
        st_nxt.redA = red && st_nxt.phase; // [RULE_05] [RULE_23]
        st_nxt.redB = red && !st_nxt.phase;
        st_nxt.pave = red; // [RULE_06]
        st_nxt.beacon = st_nxt.beaconLatch
            || (st_r.cfg[`CFG_TL_BEACON] && red && st_nxt.seq == barrier_pkg::SEQ_IDLE
                && (selMode == barrier_pkg::MODE_TEST
                    || (selMode == barrier_pkg::MODE_LOCAL && !multi))); // [RULE_18] [RULE_22]
        st_nxt.horn = (st_nxt.hornTmr != '0); // [RULE_09]
        st_nxt.lamp = (st_nxt.seq != barrier_pkg::SEQ_IDLE)
            ? (~st_nxt.pressed | {N{st_nxt.phase}}) : '0; // [RULE_10]

        // =============================================
        // AXI4-Lite slave: address and data taken in either order
        if (s_axi_awvalid && st_r.awRdy) begin
            st_nxt.awHave = 1'b1;
            st_nxt.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wRdy) begin
            st_nxt.wHave = 1'b1;
            st_nxt.wData = s_axi_wdata;
            st_nxt.wStrb = s_axi_wstrb;
        end
        if (st_r.bValid && s_axi_bready) begin
            st_nxt.bValid = 1'b0;
        end
        if (st_r.awHave && st_r.wHave && !st_r.bValid) begin
            st_nxt.awHave = 1'b0;
            st_nxt.wHave = 1'b0;
            st_nxt.bValid = 1'b1;
            wrOk = 1'b1;
            if (st_r.awAddr[3:2] == `REG_CFG >> 2) begin
                if (st_r.wStrb[0]) begin
                    st_nxt.cfg = st_r.wData[`CFG_W-1:0];
                end
            end else if (st_r.awAddr[3:2] == `REG_HORN >> 2) begin
                if (st_r.wStrb[0]) begin
                    st_nxt.hornSec = st_r.wData[7:0];
                end
            end else begin
                wrOk = 1'b0;
            end
            st_nxt.bResp = wrOk ? `RESP_OKAY : `RESP_SLVERR;
        end
        st_nxt.awRdy = !st_nxt.awHave;
        st_nxt.wRdy = !st_nxt.wHave;

        if (st_r.rValid && s_axi_rready) begin
            st_nxt.rValid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arRdy) begin
            st_nxt.rValid = 1'b1;
            st_nxt.rResp = `RESP_OKAY;
            case (s_axi_araddr[3:2])
                `REG_CFG >> 2: st_nxt.rData = {{(32 - `CFG_W){1'b0}}, st_r.cfg};
                `REG_HORN >> 2: st_nxt.rData = {24'h0, st_r.hornSec};
                `REG_STATUS >> 2: st_nxt.rData = {{(32 - `STAT_W){1'b0}}, st_r.horn,
                    st_r.beacon, st_r.emClose, selMode, st_r.head, st_r.seq};
                default: begin
                    st_nxt.rData = 32'h0;
                    st_nxt.rResp = `RESP_SLVERR;
                end
            endcase
        end
        st_nxt.arRdy = !st_nxt.rValid;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.cfg <= `CFG_RESET;
            st_r.hornSec <= `HORN_RESET;
            st_r.awRdy <= 1'b1;
            st_r.wRdy <= 1'b1;
            st_r.arRdy <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =============================================
    // Outputs
    assign openCmd = st_r.openCmd;
    assign closeCmd = st_r.closeCmd;
    assign emergencyClose = st_r.emClose;
    assign headYellow = st_r.yel;
    assign headRedA = st_r.redA;
    assign headRedB = st_r.redB;
    assign pavementLights = st_r.pave;
    assign beacons = st_r.beacon;
    assign horn = st_r.horn;
    assign stationLamp = st_r.lamp;
    assign s_axi_awready = st_r.awRdy;
    assign s_axi_wready = st_r.wRdy;
    assign s_axi_bvalid = st_r.bValid;
    assign s_axi_bresp = st_r.bResp;
    assign s_axi_arready = st_r.arRdy;
    assign s_axi_rvalid = st_r.rValid;
    assign s_axi_rdata = st_r.rData;
    assign s_axi_rresp = st_r.rResp;

    // =============================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_emg_switch_ignore: assert property ( // [RULE_01]
        selMode == barrier_pkg::MODE_EMG |=> !openCmd && !closeCmd)
        else $error("command issued in emergency mode");
    chk_dark_head_lamps: assert property ( // [RULE_02]
        st_r.head == barrier_pkg::HEAD_DARK |-> !headYellow && !headRedA && !headRedB && !pavementLights)
        else $error("lamp lit with dark head");
    chk_close_delay_done: assert property ( // [RULE_03]
        $rose(emergencyClose) |-> $past(st_r.seqTmr) == 8'(DLY - 1) || $past(st_r.seq) == barrier_pkg::SEQ_HOLD)
        else $error("emergency close before delay");
    chk_beacon_at_start: assert property ( // [RULE_04]
        start |=> beacons && st_r.seq == barrier_pkg::SEQ_DELAY)
        else $error("beacons late");
    chk_red_after_yellow: assert property ( // [RULE_05]
        st_r.seq == barrier_pkg::SEQ_DELAY && $rose(pavementLights) |-> st_r.seqTmr >= 8'(EYEL))
        else $error("red before yellow ended");
    chk_pavement_red: assert property ( // [RULE_06]
        pavementLights |-> headRedA ^ headRedB)
        else $error("pavement lights without red");
    chk_close_needs_clear: assert property ( // [RULE_07]
        $rose(emergencyClose) |-> !$past(presenceFront) && !$past(presenceBack))
        else $error("close with detector occupied");
    chk_lock_refuses: assert property ( // [RULE_11]
        st_r.seq != barrier_pkg::SEQ_IDLE |=> !openCmd && !closeCmd)
        else $error("command accepted while locked");
    chk_clear_drops: assert property ( // [RULE_12]
        latchClear && st_r.seq != barrier_pkg::SEQ_IDLE |=> !emergencyClose ##1 !emergencyClose)
        else $error("close request survived clear");
    chk_horn_starts: assert property ( // [RULE_09]
        start && st_r.hornSec != 8'h0 |=> horn)
        else $error("horn silent on activation");

    cov_activation: cover property (start ##[1:8] beacons);
    cov_deploy: cover property ($rose(emergencyClose));
    cov_test_move: cover property (selMode == barrier_pkg::MODE_TEST ##1 openCmd);
    cov_dark_return: cover property (st_r.head == barrier_pkg::HEAD_RED ##1 st_r.head == barrier_pkg::HEAD_DARK);

endmodule

// File: hdl/barrier_pkg.sv
package barrier_pkg;

    typedef enum logic [1:0] {
        MODE_EMG = 2'b00,
        MODE_TEST = 2'b01,
        MODE_LOCAL = 2'b10
    } mode_t;

    typedef enum logic [1:0] {
        HEAD_DARK = 2'b00,
        HEAD_YELLOW = 2'b01,
        HEAD_RED = 2'b10
    } head_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_DELAY = 2'b01,
        SEQ_HOLD = 2'b10,
        SEQ_CLOSED = 2'b11
    } seq_t;

endpackage

// File: test/barrier_signal_mode_controller_bench.sv
`timescale 1ns/1ps
`include "barrier_consts.svh"

module barrier_signal_mode_controller_bench;
    localparam int N = 4;
    localparam int LIMIT = 10000;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [1:0] selMode = 2'h0;
    logic farDirNotEmg = 1'h0, masterOpen = 1'h0, masterClose = 1'h0, localKey = 1'h0;
    logic localOpen = 1'h0, localClose = 1'h0, latchClear = 1'h0, presenceFront = 1'h0, presenceBack = 1'h0;
    logic [N-1:0] trigBtn = 4'h0;
    logic barrierOpen, openCmd, closeCmd, emergencyClose, headYellow, headRedA, headRedB;
    logic pavementLights, beacons, horn;
    logic [N-1:0] stationLamp;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    barrier_mode_ctrl #(.N(N), .TICK_CYCLES(4)) uut (
        .clk(clk), .rst_b(rst_b), .selMode(selMode), .farDirNotEmg(farDirNotEmg),
        .masterOpen(masterOpen), .masterClose(masterClose), .localKey(localKey),
        .localOpen(localOpen), .localClose(localClose), .trigBtn(trigBtn), .latchClear(latchClear),
        .presenceFront(presenceFront), .presenceBack(presenceBack), .barrierOpen(barrierOpen),
        .openCmd(openCmd), .closeCmd(closeCmd), .emergencyClose(emergencyClose),
        .headYellow(headYellow), .headRedA(headRedA), .headRedB(headRedB),
        .pavementLights(pavementLights), .beacons(beacons), .horn(horn), .stationLamp(stationLamp),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    barrier_unit_model unit (
        .clk(clk), .rst_b(rst_b), .openCmd(openCmd), .closeCmd(closeCmd),
        .emergencyClose(emergencyClose), .barrierOpen(barrierOpen)
    );

    // ==========================================
    // Helpers
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Yellow, one red lit, pavement lights
    task automatic head(input logic [2:0] e);
        chk("head", e, {headYellow, headRedA ^ headRedB, pavementLights});
    endtask

    task automatic go(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Ends at a falling edge, with outputs settled
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'h0;
        w = 1'h0;
        go(1);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (!aw && s_axi_awready === 1'h1) begin
                aw = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w && s_axi_wready === 1'h1) begin
                w = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end while (!(aw && w));
        do @(posedge clk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk("bresp", er, s_axi_bresp);
    endtask

    task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        go(1);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk); while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask

    // ==========================================
    // Scenarios
    task automatic emg(input logic [31:0] cfg, input int hs);
        logic l1;
        logic ra;
        axw(`REG_CFG, cfg, `RESP_OKAY);
        axw(`REG_HORN, 32'(hs), `RESP_OKAY);
        go(1);
        {presenceFront, presenceBack} <= {!cfg[0], cfg[0]};
        masterOpen <= 1'h1;
        trigBtn <= 4'h2;
        fork
            begin
                look(hs * 40 - 20);
                chk("horn on", 1, horn);
                look(40);
                chk("horn off", 0, horn);
            end
            begin
                look(1);
                chk("beacons", 1, beacons);
                chk("lamps", 4'hd, stationLamp & 4'hd);
                head(3'b100);
                chk("open", 0, openCmd);
                go(1);
                trigBtn <= 4'h0;
                look(8);
                l1 = stationLamp[1];
                look(40);
                chk("pressed lamp", 1, stationLamp[1] ^ l1);
                look(60);
                head(3'b100);
                chk("early close", 0, emergencyClose);
                look(20);
                head(3'b011);
                ra = headRedA;
                look(40);
                chk("red alternates", 1, headRedA ^ ra);
                chk("occupied", 0, emergencyClose);
                go(30);
                {presenceFront, presenceBack} <= 2'h0;
                look(4);
                chk("deploy", 1, emergencyClose);
            end
        join
        go(1);
        selMode <= barrier_pkg::MODE_TEST;
        look(4);
        chk("refused", 0, openCmd);
        go(1);
        latchClear <= 1'h1;
        go(1);
        latchClear <= 1'h0;
        look(1);
        chk("latch", 0, emergencyClose);
        chk("beacons", !cfg[0], beacons);
        for (int i = 0; i < 100 && openCmd !== 1'h1; i++) @(negedge clk);
        chk("open", 1, openCmd);
        look(12);
        head(3'b011);
        go(1);
        selMode <= barrier_pkg::MODE_EMG;
        masterOpen <= 1'h0;
        look(6);
        head(3'b000);
        chk("beacons", 0, beacons);
    endtask

    task automatic modeRun(input logic [1:0] m);
        logic t;
        t = (m == barrier_pkg::MODE_TEST);
        go(1);
        selMode <= m;
        masterClose <= t;
        masterOpen <= !t;
        localClose <= !t;
        localOpen <= t;
        localKey <= 1'h0;
        look(4);
        head(3'b100);
        chk("close in yellow", 0, closeCmd);
        look(96);
        head(3'b011);
        chk("open", 0, openCmd);
        chk("close", t, closeCmd);
        chk("beacons", !t, beacons);
        go(1);
        localKey <= 1'h1;
        trigBtn <= 4'h1;
        look(2);
        chk("close", 1, closeCmd);
        chk("open", 0, openCmd);
        chk("trigger", 0, |stationLamp | emergencyClose);
        go(1);
        trigBtn <= 4'h0;
        masterClose <= 1'h0;
        localClose <= 1'h0;
        masterOpen <= t;
        localOpen <= !t;
        look(12);
        chk("open", 1, openCmd);
        head(3'b011);
        go(1);
        selMode <= barrier_pkg::MODE_EMG;
        masterOpen <= 1'h0;
        localOpen <= 1'h0;
        localKey <= 1'h0;
        look(6);
        head(3'b000);
    endtask

    task automatic multiSpan();
        axw(`REG_CFG, 32'h4, `RESP_OKAY);
        go(1);
        selMode <= barrier_pkg::MODE_LOCAL;
        localKey <= 1'h1;
        localClose <= 1'h1;
        look(100);
        head(3'b000);
        chk("beacons", 0, beacons);
        chk("close", 1, closeCmd);
        go(1);
        localClose <= 1'h0;
        localOpen <= 1'h1;
        look(12);
        go(1);
        selMode <= barrier_pkg::MODE_EMG;
        localOpen <= 1'h0;
        localKey <= 1'h0;
        farDirNotEmg <= 1'h1;
        axw(`REG_CFG, 32'h8, `RESP_OKAY);
        go(1);
        trigBtn <= 4'h1;
        look(2);
        chk("span trigger", 0, beacons);
        head(3'b000);
        go(1);
        trigBtn <= 4'h0;
        farDirNotEmg <= 1'h0;
        axw(`REG_CFG, 32'h0, `RESP_OKAY);
    endtask

    // ==========================================
    // Main sequence and hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            finish_test();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        look(1);
        head(3'b000);
        chk("beacons", 0, beacons);
        axr(`REG_CFG, 32'h0, `RESP_OKAY);
        axr(`REG_HORN, 32'h0a, `RESP_OKAY);
        axr(4'hc, 32'h0, `RESP_SLVERR);
        axw(`REG_STATUS, 32'h1, `RESP_SLVERR);
        emg(32'h0, 10);
        emg(32'h1, 2);
        modeRun(barrier_pkg::MODE_TEST);
        axw(`REG_CFG, 32'h2, `RESP_OKAY);
        modeRun(barrier_pkg::MODE_LOCAL);
        multiSpan();
        finish_test();
    end
endmodule

// File: test/barrier_unit_model.sv
`timescale 1ns/1ps

// ==========================================
// Barrier power unit
// Open status drops as soon as a close starts; opening takes TRAVEL cycles
module barrier_unit_model #(
    parameter int TRAVEL = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic openCmd,
    input wire logic closeCmd,
    input wire logic emergencyClose,
    output logic barrierOpen
);
    int travelCnt_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            barrierOpen <= 1'h1;
            travelCnt_r <= 0;
        end else if (emergencyClose || closeCmd) begin
            barrierOpen <= 1'h0;
            travelCnt_r <= 0;
        end else if (openCmd && !barrierOpen) begin
            travelCnt_r <= travelCnt_r + 1;
            if (travelCnt_r == TRAVEL - 1) begin
                barrierOpen <= 1'h1;
            end
        end
    end
endmodule
